// File: tb/vbi_data_decode_status_tb_top.sv
// Bench reading the status bank over the serial port against an integer model.
// Assumes the checker is bound and the source model drives the decode lanes.
`timescale 1ns/1ps
`default_nettype none
`include "vbidd_consts.vh"
module vbi_data_decode_status_tb_top;
   logic clk_sys_i;
   logic rst_i;
   logic scl_r;
   logic sda_m_r;
   logic sda_o;
   logic sda_oe_n_o;
   logic field;
   logic hblank;
   logic anc_valid;
   logic [7:0] anc_byte;
   logic [4:0] done;
   logic [20:0] pdata;
   logic [1:0] ok;
   logic [7:0] v;
   logic [7:0] b;
   logic [3:0] vf;
   logic [3:0] sf;
   logic [20:0] g;
   logic [7:0] ins_q[$];
   wire logic sda_i;
   int failures;
   int checks;
   int seed;
   int ctl;
   int vd[4];
   int sd[4];
   int wid[4] = '{14, 16, 21, 20};
   assign sda_i = sda_m_r & (sda_oe_n_o | sda_o);
   vbidd_top u_vbidd_top (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_r), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .field_i(field),
      .wss_done_i(done[0]), .wss_data_i(pdata[13:0]), .wss_start_ok_i(ok[0]),
      .wss_parity_ok_i(ok[1]), .cc_done_i(done[1]), .cc_data_i(pdata[15:0]),
      .cc_start_ok_i(ok[0]), .cc_parity_ok_i(ok[1]), .edtv_done_i(done[2]),
      .edtv_data_i(pdata), .edtv_start_ok_i(ok[0]), .edtv_parity_ok_i(ok[1]),
      .cgms_done_i(done[3]), .cgms_data_i(pdata[19:0]), .cgms_start_ok_i(ok[0]),
      .guide_done_i(done[4]), .guide_data_i(pdata[15:0]), .hblank_i(hblank),
      .anc_valid_o(anc_valid), .anc_byte_o(anc_byte)
   );
   vbidd_src_model u_src (
      .clk_sys_i(clk_sys_i), .field_o(field), .hblank_o(hblank),
      .done_o(done), .data_o(pdata), .ok_o(ok)
   );
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bit9(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         tick(2);
         sda_m_r = w[i];
         tick(3);
         scl_r = 1'b1;
         tick(3);
         r[i] = sda_i;
         scl_r = 1'b0;
      end
   endtask
   task frame_edge(input logic s);
      tick(2);
      sda_m_r = s;
      tick(2);
      scl_r = 1'b1;
      tick(3);
      sda_m_r = ~s;
      tick(3);
      scl_r = ~s;
   endtask
   task wbyte(input logic [7:0] d);
      logic [8:0] r;
      bit9({d, 1'b1}, r);
      chk({7'h00, r[0]}, 8'h00);
   endtask
   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      frame_edge(1'b1);
      wbyte({`VBIDD_DEV_ADDR, 1'b0});
      wbyte(a);
      wbyte(d);
      frame_edge(1'b0);
   endtask
   task reg_rd(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] r;
      frame_edge(1'b1);
      wbyte({`VBIDD_DEV_ADDR, 1'b0});
      wbyte(a);
      frame_edge(1'b1);
      wbyte({`VBIDD_DEV_ADDR, 1'b1});
      bit9(9'h1FF, r);
      d = r[8:1];
      frame_edge(1'b0);
   endtask
   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      case (a)
         8'h90: exp_reg = {4'h0, vf};
         8'h91: exp_reg = 8'(vd[0]);
         8'h92: exp_reg = 8'(vd[0] >> 8);
         8'h93: exp_reg = 8'(vd[2]);
         8'h94: exp_reg = 8'(vd[2] >> 8);
         8'h95: exp_reg = 8'(vd[2] >> 16);
         8'h96: exp_reg = 8'(vd[3]);
         8'h97: exp_reg = 8'(vd[3] >> 8);
         8'h98: exp_reg = 8'(vd[3] >> 16);
         8'h99: exp_reg = 8'(vd[1]);
         8'h9A: exp_reg = 8'(vd[1] >> 8);
         8'hB2: exp_reg = 8'(ctl & 4);
         default: exp_reg = 8'h00;
      endcase
   endfunction
   function automatic logic [5:0] crc6(input logic [13:0] p);
      logic [5:0] c;
      c = 6'h3F;
      for (int i = 0; i < 14; i++)
         c = {c[4:0], 1'b0} ^ ((c[5] ^ p[i]) ? 6'h03 : 6'h00);
      crc6 = c;
   endfunction
   task send(input int k);
      logic [20:0] d;
      logic [1:0] okb;
      d = 21'($random(seed)) & 21'((1 << wid[k]) - 1);
      okb = 2'($random(seed));
      if (k == 3 && okb[1])
         d[19:14] = crc6(d[13:0]);
      u_src.pkt(k, d, okb);
      if (k == 1) begin
         ins_q.push_back(d[7:0]);
         ins_q.push_back(d[15:8]);
      end
      sd[k] = int'(d);
      sf[k] = (k == 3) ? okb[0] && (d[19:14] == crc6(d[13:0]) || ctl == 0) : okb[0] && okb[1];
   endtask
   task rd_all();
      // status first, then the data bytes
      for (int a = 8'h90; a <= 8'h9B; a++) begin
         reg_rd(8'(a), v);
         chk(v, exp_reg(8'(a)));
      end
      reg_rd(8'hB2, v);
      chk(v, exp_reg(8'hB2));
   endtask
   task wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(negedge clk_sys_i) begin
      if (anc_valid === 1'b1) begin
         if (ins_q.size() > 0)
            chk(anc_byte, ins_q.pop_front());
         else
            chk(anc_byte, ~anc_byte);
      end
   end
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Limit set at about two and a half times the expected run.
   initial begin
      #1_000_000;
      failures++;
      wrap_up();
   end
   initial begin
      seed = 32'hDFE1;
      failures = 0;
      checks = 0;
      ctl = 4;
      vd = '{default: 0};
      sd = '{default: 0};
      vf = 4'h0;
      sf = 4'h0;
      rst_i = 1'b1;
      scl_r = 1'b1;
      sda_m_r = 1'b1;
      tick(16);
      rst_i = 1'b0;
      rd_all();
      for (int a = 8'h90; a <= 8'h9B; a++)
         reg_wr(8'(a), 8'hFF);
      rd_all();
      for (int f = 0; f < 6; f++) begin
         b = 8'($random(seed));
         reg_wr(8'hB2, b);
         ctl = b & 4;
         for (int k = 0; k < 4; k++)
            if (f == 0 || $random(seed) % 3 != 0)
               send(k);
         if (f % 2 == 1) begin
            g = 21'($random(seed));
            ins_q.push_back(g[7:0]);
            ins_q.push_back(g[15:8]);
            u_src.pkt(4, g, 2'h0);
         end
         u_src.line(8);
         u_src.line(8);
         reg_rd(8'h90, v);
         chk(v, exp_reg(8'h90));
         u_src.flip();
         vd = sd;
         vf = sf;
         sf = 4'h0;
         rd_all();
      end
      chk(8'(ins_q.size()), 8'h00);
      wrap_up();
   end
endmodule // vbi_data_decode_status_tb_top
`default_nettype wire

// File: tb/vbidd_monitor.sv
// Port checker of the decode status bank: insertion bytes, serial drive, reset.
// Assumes binding into vbidd_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "vbidd_consts.vh"
module vbidd_monitor (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Serial port.
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // Decode and insertion.
   input wire logic cc_done_i,
   input wire logic [`VBIDD_CC_W-1:0] cc_data_i,
   input wire logic guide_done_i,
   input wire logic [`VBIDD_GUIDE_W-1:0] guide_data_i,
   input wire logic hblank_i,
   input wire logic anc_valid_o,
   input wire logic [7:0] anc_byte_o
);
   logic hb_q_r;
   logic cap_pend_r;
   logic gd_pend_r;
   logic [15:0] cap_hold_r;
   logic [15:0] gd_hold_r;
   logic rise;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   assign rise = hblank_i && !hb_q_r;
   // Bytes waiting for the next blanking interval.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         {hb_q_r, cap_pend_r, gd_pend_r} <= 3'h0;
      end else begin
         hb_q_r <= hblank_i;
         if (cc_done_i)
            {cap_pend_r, cap_hold_r} <= {1'b1, cc_data_i};
         else if (rise)
            cap_pend_r <= 1'b0;
         if (guide_done_i)
            {gd_pend_r, gd_hold_r} <= {1'b1, guide_data_i};
         else if (rise)
            gd_pend_r <= 1'b0;
      end
   end
   cap_bytes_a:
      assert property (rise && cap_pend_r |-> ##2 anc_valid_o && anc_byte_o == cap_hold_r[7:0]
         ##1 anc_valid_o && anc_byte_o == cap_hold_r[15:8])
      else $error("Caption bytes not inserted.");
   cap_absent_a:
      assert property (rise && !cap_pend_r |-> ##2 !anc_valid_o ##1 !anc_valid_o)
      else $error("Caption slot used with nothing pending.");
   guide_bytes_a:
      assert property (rise && gd_pend_r |-> ##4 anc_valid_o && anc_byte_o == gd_hold_r[7:0]
         ##1 anc_valid_o && anc_byte_o == gd_hold_r[15:8])
      else $error("Guide bytes not inserted.");
   guide_absent_a:
      assert property (rise && !gd_pend_r |-> ##4 !anc_valid_o ##1 !anc_valid_o)
      else $error("Guide slot used with nothing pending.");
   anc_blank_a:
      assert property (anc_valid_o |-> $past(hblank_i))
      else $error("Byte inserted outside blanking.");
   anc_run_a:
      assert property (anc_valid_o [*4] |=> !anc_valid_o)
      else $error("Too many inserted bytes.");
   oe_fall_a:
      assert property ($fell(sda_oe_n_o) |-> $past(scl_i, 2) && !$past(scl_i))
      else $error("Data line pulled outside its slot.");
   sda_low_a:
      assert property (sda_o == 1'b0)
      else $error("Data line driven high.");
   rst_vals_a:
      assert property (disable iff (1'b0) rst_i |=> sda_oe_n_o && !anc_valid_o && anc_byte_o == 8'h00)
      else $error("Outputs not cleared by reset.");
endmodule // vbidd_monitor
bind vbidd_top vbidd_monitor u_vbidd_monitor (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .cc_done_i(cc_done_i), .cc_data_i(cc_data_i),
   .guide_done_i(guide_done_i), .guide_data_i(guide_data_i), .hblank_i(hblank_i),
   .anc_valid_o(anc_valid_o), .anc_byte_o(anc_byte_o)
);
`default_nettype wire

// File: tb/vbidd_src_model.sv
// Behavioural video source handing decoded blanking packets and line timing to the bank.
// Assumes its tasks are entered just after a rising edge of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module vbidd_src_model (
   // Clock.
   input wire logic clk_sys_i,
   // Video side.
   output logic field_o = 1'b0,
   output logic hblank_o = 1'b0,
   output logic [4:0] done_o = 5'h00,
   output logic [20:0] data_o = 21'h000000,
   output logic [1:0] ok_o = 2'h0
);
   task pkt(input int k, input logic [20:0] d, input logic [1:0] okb);
      done_o[k] = 1'b1;
      data_o = d;
      ok_o = okb;
      @(posedge clk_sys_i);
      #1;
      // Unqualified lanes show the inverse of the last value.
      done_o = 5'h00;
      data_o = ~d;
      ok_o = ~okb;
      @(posedge clk_sys_i);
      #1;
   endtask
   task flip();
      field_o = ~field_o;
      @(posedge clk_sys_i);
      #1;
   endtask
   task line(input int n);
      hblank_o = 1'b1;
      repeat (n) @(posedge clk_sys_i);
      #1;
      hblank_o = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask
endmodule // vbidd_src_model
`default_nettype wire

// File: verilog/vbidd_consts.vh
// Constants for the blanking-interval data decode status bank.
// Assumes inclusion by bare name from each design file of the block.
`ifndef VBIDD_CONSTS_VH
`define VBIDD_CONSTS_VH

`define VBIDD_DEV_ADDR 7'h21
`define VBIDD_ADDR_STATUS 8'h90
`define VBIDD_ADDR_WSS_0 8'h91
`define VBIDD_ADDR_WSS_1 8'h92
`define VBIDD_ADDR_EDTV_0 8'h93
`define VBIDD_ADDR_EDTV_1 8'h94
`define VBIDD_ADDR_EDTV_2 8'h95
`define VBIDD_ADDR_CGMS_0 8'h96
`define VBIDD_ADDR_CGMS_1 8'h97
`define VBIDD_ADDR_CGMS_2 8'h98
`define VBIDD_ADDR_CC0 8'h99
`define VBIDD_ADDR_CC1 8'h9A
`define VBIDD_ADDR_CTL 8'hB2

`define VBIDD_ST_WSS 0
`define VBIDD_ST_CC 1
`define VBIDD_ST_EDTV 2
`define VBIDD_ST_CGMS 3
`define VBIDD_CTL_CRC_BIT 2
`define VBIDD_CTL_CRC_RESET 1'h1

`define VBIDD_WSS_W 14
`define VBIDD_CC_W 16
`define VBIDD_EDTV_W 21
`define VBIDD_CGMS_W 20
`define VBIDD_GUIDE_W 16
`define VBIDD_CGMS_PAYLOAD_W 14
`define VBIDD_CRC_W 6
`define VBIDD_CRC_POLY 6'h03
`define VBIDD_CRC_INIT 6'h3F

`endif

// File: verilog/vbidd_crc.v
// Checksum check of a copy-control packet, six bit, preset to all ones.
// Assumes the payload is given first bit in the lowest position.
`timescale 1ns/1ps
`default_nettype none
`include "vbidd_consts.vh"
module vbidd_crc (
   // Packet.
   input wire [`VBIDD_CGMS_PAYLOAD_W-1:0] data_i,
   input wire [`VBIDD_CRC_W-1:0] crc_i,
   // Result.
   output wire ok_o
);
   reg [`VBIDD_CRC_W-1:0] crc_c;
   reg fb_c;
   integer i;

   always @* begin
      crc_c = `VBIDD_CRC_INIT;
      fb_c = 1'b0;
      for (i = 0; i < `VBIDD_CGMS_PAYLOAD_W; i = i + 1) begin
         fb_c = data_i[i] ^ crc_c[`VBIDD_CRC_W-1];
         crc_c = {crc_c[`VBIDD_CRC_W-2:0], 1'b0};
         if (fb_c) begin
            crc_c = crc_c ^ `VBIDD_CRC_POLY;
         end
      end
   end

   assign ok_o = (crc_c == crc_i);
endmodule // vbidd_crc
`default_nettype wire

// File: verilog/vbidd_lane.v
// Double-buffered capture of one decoded packet and its confidence flag.
// Assumes load and field pulses are one cycle wide on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module vbidd_lane #(
   parameter W = 8
) (
   // Clock and reset.
   input wire clk_sys_i,
   input wire rst_i,
   // Decoder side.
   input wire load_i,
   input wire [W-1:0] data_i,
   input wire ok_i,
   input wire field_i,
   // Readable side.
   output reg [W-1:0] data_o,
   output reg flag_o
);
   reg [W-1:0] stage_r;
   reg stage_ok_r;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         stage_r <= {W{1'b0}};
         stage_ok_r <= 1'b0;
         data_o <= {W{1'b0}};
         flag_o <= 1'b0;
      end else begin
         if (load_i) begin
            stage_r <= data_i;
         end
         if (load_i) begin
            stage_ok_r <= ok_i;
         end else if (field_i) begin
            stage_ok_r <= 1'b0;
         end
         if (field_i) begin
            data_o <= stage_r;
            flag_o <= stage_ok_r;
         end
      end
   end
endmodule // vbidd_lane
`default_nettype wire

// File: verilog/vbidd_top.v
// Blanking-interval data decode status bank with its two-wire serial port.
// Assumes all inputs are synchronous to clk_sys_i and decode pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "vbidd_consts.vh"
module vbidd_top (
   // Clock and reset.
   input wire clk_sys_i,
   input wire rst_i,
   // Two-wire serial port.
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_n_o,
   // Field signal.
   input wire field_i,
   // Aspect signalling decode.
   input wire wss_done_i,
   input wire [`VBIDD_WSS_W-1:0] wss_data_i,
   input wire wss_start_ok_i,
   input wire wss_parity_ok_i,
   // Caption decode.
   input wire cc_done_i,
   input wire [`VBIDD_CC_W-1:0] cc_data_i,
   input wire cc_start_ok_i,
   input wire cc_parity_ok_i,
   // Enhanced-TV decode.
   input wire edtv_done_i,
   input wire [`VBIDD_EDTV_W-1:0] edtv_data_i,
   input wire edtv_start_ok_i,
   input wire edtv_parity_ok_i,
   // Copy-control decode.
   input wire cgms_done_i,
   input wire [`VBIDD_CGMS_W-1:0] cgms_data_i,
   input wire cgms_start_ok_i,
   // Program-guide decode.
   input wire guide_done_i,
   input wire [`VBIDD_GUIDE_W-1:0] guide_data_i,
   // Output stream insertion.
   input wire hblank_i,
   output reg anc_valid_o,
   output reg [7:0] anc_byte_o
);
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_AACK = 3'd2;
   localparam S_RX = 3'd3;
   localparam S_RACK = 3'd4;
   localparam S_TX = 3'd5;
   localparam S_TACK = 3'd6;

   reg field_d_r;
   reg crc_en_r;
   reg scl_d_r;
   reg sda_d_r;
   reg [2:0] state_r;
   reg [3:0] bitcnt_r;
   reg [7:0] shift_r;
   reg [7:0] tx_r;
   reg [7:0] ptr_r;
   reg rw_r;
   reg first_r;
   reg hblank_d_r;
   reg cc_pend_r;
   reg guide_pend_r;
   reg [`VBIDD_CC_W-1:0] cc_buf_r;
   reg [`VBIDD_GUIDE_W-1:0] guide_buf_r;
   reg [2:0] ins_cnt_r;
   reg [7:0] rd_c;

   wire field_evt;
   wire crc_ok;
   wire cgms_ok;
   wire [`VBIDD_WSS_W-1:0] wss_q;
   wire [`VBIDD_CC_W-1:0] cc_q;
   wire [`VBIDD_EDTV_W-1:0] edtv_q;
   wire [`VBIDD_CGMS_W-1:0] cgms_q;
   wire wss_f;
   wire cc_f;
   wire edtv_f;
   wire cgms_f;
   wire start_c;
   wire stop_c;
   wire rise_c;
   wire fall_c;
   wire hb_rise;

   assign field_evt = field_i ^ field_d_r;
   assign start_c = scl_i & scl_d_r & sda_d_r & ~sda_i;
   assign stop_c = scl_i & scl_d_r & ~sda_d_r & sda_i;
   assign rise_c = scl_i & ~scl_d_r;
   assign fall_c = ~scl_i & scl_d_r;
   assign hb_rise = hblank_i & ~hblank_d_r;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         field_d_r <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         hblank_d_r <= 1'b0;
      end else begin
         field_d_r <= field_i;
         scl_d_r <= scl_i;
         sda_d_r <= sda_i;
         hblank_d_r <= hblank_i;
      end
   end

   vbidd_crc u_crc (
      .data_i(cgms_data_i[`VBIDD_CGMS_PAYLOAD_W-1:0]),
      .crc_i(cgms_data_i[`VBIDD_CGMS_W-1:`VBIDD_CGMS_PAYLOAD_W]),
      .ok_o(crc_ok)
   );

   assign cgms_ok = cgms_start_ok_i & (crc_ok | ~crc_en_r);

   vbidd_lane #(.W(`VBIDD_WSS_W)) u_wss (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(wss_done_i),
      .data_i(wss_data_i),
      .ok_i(wss_start_ok_i & wss_parity_ok_i),
      .field_i(field_evt),
      .data_o(wss_q),
      .flag_o(wss_f)
   );

   vbidd_lane #(.W(`VBIDD_CC_W)) u_cc (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(cc_done_i),
      .data_i(cc_data_i),
      .ok_i(cc_start_ok_i & cc_parity_ok_i),
      .field_i(field_evt),
      .data_o(cc_q),
      .flag_o(cc_f)
   );

   vbidd_lane #(.W(`VBIDD_EDTV_W)) u_edtv (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(edtv_done_i),
      .data_i(edtv_data_i),
      .ok_i(edtv_start_ok_i & edtv_parity_ok_i),
      .field_i(field_evt),
      .data_o(edtv_q),
      .flag_o(edtv_f)
   );

   vbidd_lane #(.W(`VBIDD_CGMS_W)) u_cgms (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(cgms_done_i),
      .data_i(cgms_data_i),
      .ok_i(cgms_ok),
      .field_i(field_evt),
      .data_o(cgms_q),
      .flag_o(cgms_f)
   );

   // Read data for the current register pointer.
   always @* begin
      case (ptr_r)
         `VBIDD_ADDR_STATUS: rd_c = {4'h0, cgms_f, edtv_f, cc_f, wss_f};
         `VBIDD_ADDR_WSS_0: rd_c = wss_q[7:0];
         `VBIDD_ADDR_WSS_1: rd_c = {2'b00, wss_q[13:8]};
         `VBIDD_ADDR_EDTV_0: rd_c = edtv_q[7:0];
         `VBIDD_ADDR_EDTV_1: rd_c = edtv_q[15:8];
         `VBIDD_ADDR_EDTV_2: rd_c = {3'b000, edtv_q[20:16]};
         `VBIDD_ADDR_CGMS_0: rd_c = cgms_q[7:0];
         `VBIDD_ADDR_CGMS_1: rd_c = cgms_q[15:8];
         `VBIDD_ADDR_CGMS_2: rd_c = {4'h0, cgms_q[19:16]};
         `VBIDD_ADDR_CC0: rd_c = cc_q[7:0];
         `VBIDD_ADDR_CC1: rd_c = cc_q[15:8];
         `VBIDD_ADDR_CTL: rd_c = {5'h00, crc_en_r, 2'b00};
         default: rd_c = 8'h00;
      endcase
   end

   // Serial port slave with auto-incrementing register pointer.
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         bitcnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         first_r <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
         crc_en_r <= `VBIDD_CTL_CRC_RESET;
      end else if (start_c) begin
         state_r <= S_ADDR;
         bitcnt_r <= 4'h0;
         sda_oe_n_o <= 1'b1;
      end else if (stop_c) begin
         state_r <= S_IDLE;
         sda_oe_n_o <= 1'b1;
      end else if (rise_c) begin
         case (state_r)
            S_ADDR,
            S_RX: begin
               shift_r <= {shift_r[6:0], sda_i};
               bitcnt_r <= bitcnt_r + 4'h1;
            end
            S_TACK: begin
               if (sda_i) begin
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= state_r;
            end
         endcase
      end else if (fall_c) begin
         case (state_r)
            S_ADDR: begin
               if (bitcnt_r == 4'h8) begin
                  if (shift_r[7:1] == `VBIDD_DEV_ADDR) begin
                     rw_r <= shift_r[0];
                     first_r <= ~shift_r[0];
                     sda_oe_n_o <= 1'b0;
                     state_r <= S_AACK;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end
            end
            S_AACK,
            S_TACK: begin
               if (rw_r) begin
                  tx_r <= rd_c;
                  sda_oe_n_o <= rd_c[7];
                  bitcnt_r <= 4'h1;
                  ptr_r <= ptr_r + 8'h01;
                  state_r <= S_TX;
               end else begin
                  sda_oe_n_o <= 1'b1;
                  bitcnt_r <= 4'h0;
                  state_r <= S_RX;
               end
            end
            S_RX: begin
               if (bitcnt_r == 4'h8) begin
                  if (first_r) begin
                     ptr_r <= shift_r;
                     first_r <= 1'b0;
                  end else begin
                     if (ptr_r == `VBIDD_ADDR_CTL) begin
                        crc_en_r <= shift_r[`VBIDD_CTL_CRC_BIT];
                     end
                     ptr_r <= ptr_r + 8'h01;
                  end
                  sda_oe_n_o <= 1'b0;
                  state_r <= S_RACK;
               end
            end
            S_RACK: begin
               sda_oe_n_o <= 1'b1;
               bitcnt_r <= 4'h0;
               state_r <= S_RX;
            end
            S_TX: begin
               if (bitcnt_r == 4'h8) begin
                  sda_oe_n_o <= 1'b1;
                  state_r <= S_TACK;
               end else begin
                  sda_oe_n_o <= tx_r[6];
                  tx_r <= {tx_r[6:0], 1'b0};
                  bitcnt_r <= bitcnt_r + 4'h1;
               end
            end
            default: begin
               sda_oe_n_o <= 1'b1;
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Insertion of caption and guide bytes into horizontal blanking.
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cc_pend_r <= 1'b0;
         guide_pend_r <= 1'b0;
         cc_buf_r <= {`VBIDD_CC_W{1'b0}};
         guide_buf_r <= {`VBIDD_GUIDE_W{1'b0}};
         ins_cnt_r <= 3'd0;
         anc_valid_o <= 1'b0;
         anc_byte_o <= 8'h00;
      end else begin
         anc_valid_o <= 1'b0;
         if (hb_rise) begin
            ins_cnt_r <= 3'd4;
         end else if (ins_cnt_r != 3'd0 && hblank_i) begin
            ins_cnt_r <= ins_cnt_r - 3'd1;
            if (cc_pend_r && ins_cnt_r > 3'd2) begin
               anc_valid_o <= 1'b1;
               anc_byte_o <= (ins_cnt_r == 3'd4) ? cc_buf_r[7:0] : cc_buf_r[15:8];
            end
            if (guide_pend_r && ins_cnt_r <= 3'd2) begin
               anc_valid_o <= 1'b1;
               anc_byte_o <= (ins_cnt_r == 3'd2) ? guide_buf_r[7:0] : guide_buf_r[15:8];
            end
         end else begin
            ins_cnt_r <= 3'd0;
         end
         if (cc_done_i) begin
            cc_buf_r <= cc_data_i;
            cc_pend_r <= 1'b1;
         end else if (hblank_i && ins_cnt_r == 3'd3) begin
            cc_pend_r <= 1'b0;
         end
         if (guide_done_i) begin
            guide_buf_r <= guide_data_i;
            guide_pend_r <= 1'b1;
         end else if (hblank_i && ins_cnt_r == 3'd1) begin
            guide_pend_r <= 1'b0;
         end
      end
   end
endmodule // vbidd_top
`default_nettype wire
